// ---- hdl/dbg_ack_pkg.sv ----
// constants for the debug serial acknowledge handshake
// assumes a single core clock domain feeding the vco-derived tick
package dbg_ack_pkg;
	localparam int unsigned SERIAL_DIV = 8;
	localparam int unsigned ACK_LOW_TICKS = 16;
	localparam int unsigned ACK_MIN_DELAY_TICKS = 32;
	localparam int unsigned CMD_END_TICK = 16;
	localparam int unsigned SPEEDUP_CYCLES = 1;
	localparam int unsigned CNT_W = 6;
	localparam int unsigned DIV_W = 3;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_END,
		ST_PENDING,
		ST_ACK_LOW,
		ST_SPEEDUP
	} ack_state_t;
endpackage : dbg_ack_pkg

// ---- hdl/serial_debug_ack_handshake.sv ----
// acknowledge pulse generator for the single-wire debug pin
// assumes vco_clk_en marks vco cycles in core_clk; bit decoder and cpu are external
// Function
// - serial clock tick is the vco rate divided by DIV, eight by default
// - acknowledge drives pin low sixteen serial ticks then brief high speedup
// - acknowledge only after the cpu reports the command executed
// - acknowledge starts no sooner than thirty-two serial ticks after command end
// - command end is the sixteenth serial tick of its last bit
// - no upper limit on delay; pending waits for execution indefinitely
// - wait or stop before execution suppresses the acknowledge
// - wait or stop entry before execution discards the pending command for good
`timescale 1ns/1ns
module serial_debug_ack_handshake
	import dbg_ack_pkg::*;
#(
	parameter int unsigned DIV = SERIAL_DIV,
	parameter int unsigned LOW_TICKS = ACK_LOW_TICKS,
	parameter int unsigned MIN_DELAY = ACK_MIN_DELAY_TICKS,
	parameter int unsigned END_TICK = CMD_END_TICK,
	parameter int unsigned SPEEDUP = SPEEDUP_CYCLES
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic vco_clk_en,
	input wire logic handshake_enable,
	input wire logic last_bit_start,
	input wire logic cmd_executed,
	input wire logic low_power_entry,
	input wire logic debug_serial_pin_i,
	output logic debug_serial_pin_o,
	output logic debug_serial_pin_oe,
	output logic serial_tick,
	output logic cmd_pending,
	output logic ack_busy
);
	ack_state_t state_q, state_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] delay_q, delay_d;
	logic executed_q, executed_d;
	logic pin_o_q, pin_o_d;
	logic pin_oe_q, pin_oe_d;
	logic tick;

	// terminal counts, cut to the counter widths on purpose
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
	localparam logic [CNT_W-1:0] END_LAST = CNT_W'(END_TICK - 1);
	localparam logic [CNT_W-1:0] DELAY_DONE = CNT_W'(MIN_DELAY);
	localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(LOW_TICKS - 1);
	localparam logic [CNT_W-1:0] SPD_LAST = CNT_W'(SPEEDUP - 1);

	always_comb begin
		div_d = div_q;
		tick = 1'b0;
		if (vco_clk_en) begin
			if (div_q == DIV_LAST) begin
				div_d = '0;
				tick = 1'b1;
			end else begin
				div_d = div_q + DIV_W'(1);
			end
		end
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		delay_d = delay_q;
		executed_d = executed_q;
		pin_o_d = 1'b1;
		pin_oe_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				executed_d = 1'b0;
				if (last_bit_start && handshake_enable) begin
					state_d = ST_WAIT_END;
					cnt_d = '0;
				end
			end
			ST_WAIT_END: begin
				if (cmd_executed) begin
					executed_d = 1'b1;
				end
				if (tick) begin
					cnt_d = cnt_q + CNT_W'(1);
					if (cnt_q == END_LAST) begin
						state_d = ST_PENDING;
						delay_d = '0;
					end
				end
			end
			ST_PENDING: begin
				if (cmd_executed) begin
					executed_d = 1'b1;
				end
				if (tick && delay_q != DELAY_DONE) begin
					delay_d = delay_q + CNT_W'(1);
				end
				if ((executed_q || cmd_executed) && delay_q == DELAY_DONE) begin
					state_d = ST_ACK_LOW;
					cnt_d = '0;
				end
			end
			ST_ACK_LOW: begin
				pin_o_d = 1'b0;
				pin_oe_d = 1'b1;
				// only ticks seen with the pin already low count, so all sixteen fall inside
				if (tick && pin_oe_q) begin
					cnt_d = cnt_q + CNT_W'(1);
					if (cnt_q == LOW_LAST) begin
						state_d = ST_SPEEDUP;
						cnt_d = '0;
						pin_o_d = 1'b1;
					end
				end
			end
			ST_SPEEDUP: begin
				pin_o_d = 1'b1;
				pin_oe_d = 1'b1;
				cnt_d = cnt_q + CNT_W'(1);
				if (cnt_q == SPD_LAST) begin
					state_d = ST_IDLE;
					pin_oe_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (low_power_entry && !executed_q && !cmd_executed &&
			(state_q == ST_WAIT_END || state_q == ST_PENDING)) begin
			state_d = ST_IDLE;
			executed_d = 1'b0;
			pin_o_d = 1'b1;
			pin_oe_d = 1'b0;
		end
	end

	// divider group
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// control group
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			delay_q <= '0;
			executed_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			delay_q <= delay_d;
			executed_q <= executed_d;
		end
	end

	// pin group; reset releases the pin so the host pull-up holds it high
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pin_o_q <= 1'b1;
			pin_oe_q <= 1'b0;
		end else begin
			pin_o_q <= pin_o_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	// pin input unused here; the bit decoder outside samples it
	logic unused_pin;
	assign unused_pin = debug_serial_pin_i;
	assign debug_serial_pin_o = pin_o_q;
	assign debug_serial_pin_oe = pin_oe_q;
	assign serial_tick = tick;
	assign cmd_pending = (state_q == ST_WAIT_END) || (state_q == ST_PENDING);
	assign ack_busy = (state_q == ST_ACK_LOW) || (state_q == ST_SPEEDUP);
endmodule : serial_debug_ack_handshake

// ---- dv/ack_properties.sv ----
// assertions on the ack handshake top ports
// assumes one core clock, bound after endmodule
`timescale 1ns/1ns
module ack_checker (input wire logic core_clk, resetn, vco_clk_en, handshake_enable,
	last_bit_start, cmd_executed, low_power_entry, debug_serial_pin_o,
	debug_serial_pin_oe, serial_tick, cmd_pending, ack_busy);
	logic [3:0] vc_q;
	logic [7:0] tk_q;
	logic ex_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vc_q <= 4'h0;
			tk_q <= 8'h0;
			ex_q <= 1'b0;
		end else begin
			vc_q <= serial_tick ? 4'h0 : vc_q + 4'(vco_clk_en);
			tk_q <= cmd_pending ? tk_q + 8'(serial_tick) : 8'h0;
			ex_q <= cmd_pending & (ex_q | cmd_executed);
		end
	end
	tick_period_a: assert property (serial_tick |-> vco_clk_en && vc_q == 4'h7)
		else $error("tick spacing");
	low_hold_a: assert property ($rose(ack_busy) |=>
		(debug_serial_pin_oe && !debug_serial_pin_o)[*8]) else $error("ack low short");
	speedup_a: assert property ($fell(debug_serial_pin_oe) |->
		$past(debug_serial_pin_o) && !$past(debug_serial_pin_o, 2)) else $error("no speedup");
	oe_cause_a: assert property ($rose(debug_serial_pin_oe) |->
		$past(ack_busy) && !$past(ack_busy, 2)) else $error("drive without busy");
	exec_first_a: assert property ($rose(ack_busy) |-> ex_q)
		else $error("ack before execution");
	min_delay_a: assert property ($rose(ack_busy) |-> tk_q >= 8'h30)
		else $error("ack too early");
	lp_drop_a: assert property (cmd_pending && low_power_entry && !cmd_executed && !ex_q
		|=> (!cmd_pending && !ack_busy)[*8]) else $error("sleep kept command");
	take_a: assert property (last_bit_start && !cmd_pending && !ack_busy
		|=> cmd_pending == handshake_enable) else $error("command take wrong");
	cover property ($rose(ack_busy));
	cover property (cmd_pending && low_power_entry);
	cover property (last_bit_start && cmd_pending);
endmodule : ack_checker
bind serial_debug_ack_handshake ack_checker chk_u (.core_clk, .resetn, .vco_clk_en,
	.handshake_enable, .last_bit_start, .cmd_executed, .low_power_entry, .debug_serial_pin_o,
	.debug_serial_pin_oe, .serial_tick, .cmd_pending, .ack_busy);

// ---- dv/host_pod_model.sv ----
// host pod model: pull-up on the pin, measures ack low pulses
// assumes pin drive and enable come straight from the device
`timescale 1ns/1ns
module host_pod_model (input wire logic core_clk, input wire logic pin_o,
	input wire logic pin_oe, output logic pin, output logic ack_seen, output int low_len);
	int cnt = 0;
	initial ack_seen = 1'b0;
	assign pin = pin_oe ? pin_o : 1'b1;
	always @(posedge core_clk) begin
		ack_seen <= 1'b0;
		if (!pin) cnt <= cnt + 1;
		else if (cnt != 0) begin
			ack_seen <= 1'b1;
			low_len <= cnt;
			cnt <= 0;
		end
	end
endmodule : host_pod_model

// ---- dv/tb.sv ----
// self-checking bench for the ack handshake
// assumes vco enable high during ack tests (tick every eight cycles), random later
`timescale 1ns/1ns
module tb import dbg_ack_pkg::*; ;
	logic core_clk = 0, resetn = 0, lbs = 0, en = 0, ex = 0, lp = 0;
	logic o, oe, tk, pend, busy, pin, ack, vco = 1'b1, jit = 1'b0;
	int len, miscompares = 0, cmp_count = 0, acks = 0, seed = 32'h30df, q[$];
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) vco <= !jit || ($random(seed) % 2 == 0);
	serial_debug_ack_handshake dut_u (.core_clk, .resetn, .vco_clk_en(vco),
		.handshake_enable(en), .last_bit_start(lbs), .cmd_executed(ex), .low_power_entry(lp),
		.debug_serial_pin_i(pin), .debug_serial_pin_o(o), .debug_serial_pin_oe(oe),
		.serial_tick(tk), .cmd_pending(pend), .ack_busy(busy));
	host_pod_model pod_u (.core_clk, .pin_o(o), .pin_oe(oe), .pin, .ack_seen(ack), .low_len(len));
	task chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			miscompares++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// next command only after pend and busy clear
	task automatic cmd(input logic e, input logic drop, input int w);
		@(posedge core_clk);
		lbs <= 1'b1;
		en <= e;
		if (e && !drop) q.push_back(ACK_LOW_TICKS);
		@(posedge core_clk);
		lbs <= 1'b0;
		repeat (w) @(posedge core_clk);
		lbs <= 1'b1;
		ex <= !drop;
		lp <= drop;
		@(posedge core_clk);
		lbs <= 1'b0;
		ex <= 1'b0;
		lp <= 1'b0;
		for (int i = 0; i < 900 && (pend || busy); i++) @(posedge core_clk);
		repeat (3) @(posedge core_clk);
	endtask : cmd
	always @(posedge core_clk) if (ack) begin
		acks++;
		if (q.size() > 0) chk(q.pop_front(), (len + 7) >> 3);
		else chk(0, len);
	end
	initial begin
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 3; i++) cmd(1'b1, 1'b0, 1 + $unsigned($random(seed)) % 300);
		$display("ack test done");
		jit <= 1'b1;
		cmd(1'b0, 1'b0, 40);
		cmd(1'b1, 1'b1, 20);
		repeat (600) @(posedge core_clk);
		chk(3, acks);
		$display("refusal test done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		stop_test();
	end
endmodule : tb
